// ---- bench/pin_side_model.sv ----
// far-side model: key pins, interrupt pin and timer 3 underflow
`timescale 1ns/1ps
module pin_side_model (
    input wire logic aclk,
    input wire logic [3:0] p0_press,
    input wire logic t3_req,
    input wire logic int_drive,
    output logic [3:0] port_zero,
    output logic [3:0] port_one,
    output logic ext_int_pin,
    output logic timer3_underflow
);
    logic t3_last;
    // pressed keys pull low; idle pins rest high on pull-ups
    assign port_zero = ~p0_press;
    assign port_one = 4'hf;
    assign ext_int_pin = int_drive;
    // one pulse per request, as the timer would give
    always_ff @(posedge aclk)
    begin
        t3_last <= t3_req;
        timer3_underflow <= t3_req & ~t3_last;
    end
endmodule // pin_side_model

// ---- bench/test_power_down_wakeup_control.sv ----
// self-checking bench for the power-down and wakeup controller
`timescale 1ns/1ps
module test_power_down_wakeup_control
    import pdw_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, int_drive;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, ext_int_pin, timer3_underflow, timer_counter_out, cold_reset;
    logic osc_run, lcd_on, cpu_halt, cpu_restart, warm_flag, vdrop_reset_enable, t3_req;
    logic combined_counter_pin_out, combined_counter_pin_oe, watchdog_restart, ext0_irq_flag;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
    logic [3:0] s_axi_wstrb, port_zero, port_one, port0_pullup, port1_pullup, p0_press, pu;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0, wd_cnt = 0;
    power_down_wakeup_control #(.ADDR_W(8)) uut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .port_zero, .port_one, .ext_int_pin, .timer3_underflow,
        .timer_counter_out, .cold_reset, .port0_pullup, .port1_pullup, .osc_run, .lcd_on,
        .cpu_halt, .cpu_restart, .warm_flag, .combined_counter_pin_out,
        .combined_counter_pin_oe, .vdrop_reset_enable, .watchdog_restart, .ext0_irq_flag);
    pin_side_model partner (.aclk, .p0_press, .t3_req, .port_zero, .port_one, .ext_int_pin,
        .timer3_underflow, .int_drive);
    // 40 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: valids held until each ready, bready until bvalid
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
            rsp = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid;
            v = s_axi_rdata;
            rsp = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
        #1;
    endtask
    // bounded wait for the restart pulse after a wake
    task wait_restart;
        int n;
        n = 0;
        while (cpu_restart !== 1'b1 && n < 40)
        begin
            @(posedge aclk);
            #1;
            n++;
        end
        chk("restart", 32'(cpu_restart), 32'h0000_0001);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (watchdog_restart) wd_cnt <= wd_cnt + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            close_out;
        end
    end
    initial
    begin
        seed = 32'h0000_0048;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {aresetn, timer_counter_out, cold_reset, t3_req, int_drive} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, p0_press} = '0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk("warm", 32'(warm_flag), 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            v = xs();
            pu = v[3:0];
            timer_counter_out <= v[4];
            wr(OFF_P0PU, 32'(pu));
            chk("pu0", 32'(port0_pullup), 32'(pu));
            chk("cnt", 32'(combined_counter_pin_out), 32'(timer_counter_out));
            rd(OFF_P0PU);
            chk("pu0 rd", v, 32'(pu));
            wr(OFF_P1PU, 32'(~pu));
            chk("pu1", 32'(port1_pullup), {28'h000_0000, ~pu});
        end
        rd(8'h3c);
        chk("resp", 32'(rsp), 32'(RESP_SLVERR));
        wr(8'h3c, 32'h0000_0000);
        chk("bresp", 32'(rsp), 32'(RESP_SLVERR));
        wr(OFF_CMD, 32'h0000_0004);
        chk("noarm", 32'(cpu_halt), 32'h0000_0000);
        // ram-hold sleep, counter pin released, timer pulse must not wake
        wr(OFF_KEYWAKE, 32'h0000_0001);
        wr(OFF_CPUCTRL, 32'h0000_7fff);
        wr(OFF_CPUSTATE, 32'h0000_000a);
        wr(OFF_CMD, 32'h0000_0040);
        chk("wdog", 32'(wd_cnt), 32'h0000_0001);
        wr(OFF_CMD, 32'h0000_0001);
        wr(OFF_CMD, 32'h0000_0004);
        chk("halt", 32'(cpu_halt), 32'h0000_0001);
        chk("osc", 32'({osc_run, lcd_on}), 32'h0000_0000);
        chk("oe", 32'(combined_counter_pin_oe), 32'h0000_0000);
        chk("vdrop", 32'(vdrop_reset_enable), 32'h0000_0000);
        t3_req <= 1'b1;
        repeat (10) @(posedge aclk);
        #1;
        chk("t3 wake", 32'(cpu_halt), 32'h0000_0001);
        @(posedge aclk);
        p0_press <= 4'h1;
        wait_restart;
        @(posedge aclk);
        p0_press <= 4'h0;
        #1;
        chk("warm", 32'(warm_flag), 32'h0000_0001);
        rd(OFF_STATUS);
        chk("from ram", 32'(v[6]), 32'h0000_0001);
        rd(OFF_CPUSTATE);
        chk("stack", v, 32'(STACK_INIT));
        rd(OFF_CPUCTRL);
        chk("ctrl", v, 32'h0000_6000);
        rd(OFF_KEYWAKE);
        chk("kw", v, 32'h0000_0001);
        // falling int edge while running raises the flag that wake must drop
        int_drive <= 1'b1;
        repeat (4) @(posedge aclk);
        int_drive <= 1'b0;
        repeat (4) @(posedge aclk);
        #1;
        chk("ext0", 32'(ext0_irq_flag), 32'h0000_0001);
        // clock-run sleep entered with the timer flag already set
        wr(OFF_CMD, 32'h0000_0020);
        wr(OFF_CMD, 32'h0000_0001);
        wr(OFF_CMD, 32'h0000_0002);
        wait_restart;
        rd(OFF_STATUS);
        chk("t3f", 32'(v[1]), 32'h0000_0001);
        chk("ext0 wake", 32'(v[2]), 32'h0000_0000);
        @(posedge aclk);
        cold_reset <= 1'b1;
        @(posedge aclk);
        cold_reset <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
        chk("cold", 32'(warm_flag), 32'h0000_0000);
        close_out;
    end
endmodule // test_power_down_wakeup_control

// ---- rtl/pdw_pkg.sv ----
// shared constants and types for the power-down and wakeup controller
package pdw_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_KEYWAKE = 8'h08;
    localparam logic [7:0] OFF_P1COND = 8'h0c;
    localparam logic [7:0] OFF_EXTWAKE = 8'h10;
    localparam logic [7:0] OFF_P0PU = 8'h14;
    localparam logic [7:0] OFF_P1PU = 8'h18;
    localparam logic [7:0] OFF_EXTCTRL = 8'h1c;
    localparam logic [7:0] OFF_CPUCTRL = 8'h20;
    localparam logic [7:0] OFF_CPUSTATE = 8'h24;
    // command register bits, each a one-shot instruction
    localparam int CMD_ARM = 0;
    localparam int CMD_CLK_SLEEP = 1;
    localparam int CMD_RAM_SLEEP = 2;
    localparam int CMD_VDROP_EN = 3;
    localparam int CMD_T3F_CLEAR = 4;
    localparam int CMD_T3F_SET = 5;
    localparam int CMD_WD_RESTART = 6;
    localparam int CMD_EXT0_CLEAR = 7;
    // wake configuration fields
    localparam int EXTW_ENABLE = 0;
    localparam int EXTW_EDGE = 1;
    localparam int EXTC_EDGE_RISE = 2;
    localparam int EXTC_RET_HIGH = 3;
    // cpu control register fields
    localparam int CPU_TMRA_LSB = 8;
    localparam int CPU_IRQ_EN = 12;
    localparam int CPU_CSEL_LSB = 13;
    // reset and reinit values
    localparam logic [2:0] STACK_INIT = 3'h7;
    localparam logic [1:0] CNT_SEL_INPUT = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_CLK_SLEEP = 2'b01,
        ST_RAM_SLEEP = 2'b10,
        ST_WAKE = 2'b11
    } pd_state_t;
endpackage

// ---- rtl/power_down_wakeup_control.sv ----
// power-down modes, wake sources, warm/cold start and register retention
//
// Behaviour
// - warm-start flag readable so software can skip on warm start
// - timer 3 flag keeps its value across clock-run sleep
// - wake reinitialises program position, carry and stack level
// - return from ram-hold sleep sets stack level to 7
// - config, pull-up, wake, timer, lcd, clock and drive registers kept
// - irq control pair, timer control a, ext irq flag, irq enable cleared
// - clock-run sleep keeps lcd and timer 3; ram-hold stops them
// - timers 1 and 2 state treated as undefined after return
// - unlisted state undefined after ram-hold; software reinitialises it
// - voltage-drop reset stays on in sleep only if enabled before
// - ram-hold sleep drives counter pin low, unless select bits 11
// - clock-run sleep ends on enabled external wake or timer 3 flag
// - ram-hold sleep ends only on external wake, never timer flag
// - wake, pull-up and ext irq registers written and read by transfer
// - key wake enabled per pin pair; port zero wakes on falling edge
// - port one wake by edge or level, polarity per pair
// - int pin return level in ext control, mode and enable in wake reg
// - wake by int pin return level does not set ext irq flag
// - timer 3 flag set by underflow or software; underflow ignored in ram-hold sleep
// - timer 3 flag already set at clock-run sleep entry wakes at once
// - pull-ups switched individually per pin of ports zero and one
// - sleep instruction is a no-op unless arm came immediately before
// - warm start restarts at address zero with warm flag set
// - cold start restarts at address zero with warm flag cleared
`timescale 1ns/1ps
module power_down_wakeup_control
    import pdw_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] port_zero,
    input wire logic [3:0] port_one,
    input wire logic ext_int_pin,
    input wire logic timer3_underflow,
    input wire logic timer_counter_out,
    input wire logic cold_reset,
    output logic [3:0] port0_pullup,
    output logic [3:0] port1_pullup,
    output logic osc_run,
    output logic lcd_on,
    output logic cpu_halt,
    output logic cpu_restart,
    output logic warm_flag,
    output logic combined_counter_pin_out,
    output logic combined_counter_pin_oe,
    output logic vdrop_reset_enable,
    output logic watchdog_restart,
    output logic ext0_irq_flag
);
    // decode needs the full eight-bit offset
    if (ADDR_W < 8)
    begin : g_addr_check
        $error("address too narrow for register map");
    end

    typedef struct packed {
        pd_state_t state;
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic int_prev;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic armed;
        logic warm;
        logic t3f;
        logic ext0;
        logic irq_en;
        logic vdrop_en;
        logic from_ram;
        logic [3:0] keywake_en;
        logic [3:0] p1_cond;
        logic [3:0] ext_cfg;
        logic [3:0] p0_pu;
        logic [3:0] p1_pu;
        logic [3:0] ext_ctrl;
        logic [7:0] irq_pair;
        logic [3:0] tmr_a;
        logic [1:0] cnt_sel;
        logic [2:0] stack;
        logic carry;
        logic osc_run;
        logic lcd_on;
        logic cpu_halt;
        logic cpu_restart;
        logic cnt_out;
        logic cnt_oe;
        logic vdrop_rst_en;
        logic wd_restart;
    } ctl_t;

    localparam ctl_t RST_VAL = '{state: ST_RUN, stack: STACK_INIT, osc_run: 1'b1,
        lcd_on: 1'b1, cnt_oe: 1'b1, vdrop_rst_en: 1'b1, default: '0};

    ctl_t st;
    ctl_t next_st;
    wake_if wk ();

    // known register offsets; used by both read and write decode
    function automatic logic addr_ok(input logic [7:0] a);
        return a inside {OFF_CMD, OFF_STATUS, OFF_KEYWAKE, OFF_P1COND, OFF_EXTWAKE,
            OFF_P0PU, OFF_P1PU, OFF_EXTCTRL, OFF_CPUCTRL, OFF_CPUSTATE};
    endfunction

    // byte-lane merge for the low two lanes; upper lanes hold nothing
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
        input logic [1:0] strb);
        return {strb[1] ? nv[15:8] : old[15:8], strb[0] ? nv[7:0] : old[7:0]};
    endfunction

    // register readback view, shared by all read paths
    function automatic logic [15:0] read_reg(input ctl_t s, input logic [7:0] a);
        case (a)
            OFF_STATUS: return {s.carry, s.stack, 2'b00, s.state, 1'b0, s.from_ram,
                s.armed, s.vdrop_en, s.irq_en, s.ext0, s.t3f, s.warm};
            OFF_KEYWAKE: return {12'h000, s.keywake_en};
            OFF_P1COND: return {12'h000, s.p1_cond};
            OFF_EXTWAKE: return {12'h000, s.ext_cfg};
            OFF_P0PU: return {12'h000, s.p0_pu};
            OFF_P1PU: return {12'h000, s.p1_pu};
            OFF_EXTCTRL: return {12'h000, s.ext_ctrl};
            OFF_CPUCTRL: return {1'b0, s.cnt_sel, s.irq_en, s.tmr_a, s.irq_pair};
            OFF_CPUSTATE: return {12'h000, s.carry, s.stack};
            default: return 16'h0000;
        endcase
    endfunction

    // configuration and synchronised pins to the detector
    assign wk.keywake_en = st.keywake_en;
    assign wk.p1_cond = st.p1_cond;
    assign wk.ext_cfg = st.ext_cfg;
    assign wk.ret_high = st.ext_ctrl[EXTC_RET_HIGH];
    assign wk.p0 = st.sync2[3:0];
    assign wk.p1 = st.sync2[7:4];
    assign wk.int_pin = st.sync2[8];

    wake_detect u_wake_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .wk(wk.det)
    );

    always_comb
    begin
        logic wr_go;
        logic [15:0] wv;
        logic [15:0] cmd;
        wr_go = 1'b0;
        wv = 16'h0000;
        cmd = 16'h0000;
        next_st = st;
        // two flops on every port and int pin before any logic sees it; timer and reset inputs are used directly
        next_st.sync1 = {ext_int_pin, port_one, port_zero};
        next_st.sync2 = st.sync1;
        next_st.int_prev = st.sync2[8];
        next_st.cpu_restart = 1'b0;
        next_st.wd_restart = 1'b0;

        // write channel: address and data taken in any order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_have = 1'b1;
            next_st.awaddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_have = 1'b1;
            next_st.wdata = s_axi_wdata[15:0];
            next_st.wstrb = s_axi_wstrb[1:0];
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        if (st.aw_have && st.w_have && !st.bvalid)
        begin
            wr_go = 1'b1;
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addr_ok(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.awready = !next_st.aw_have && !next_st.bvalid;
        next_st.wready = !next_st.w_have && !next_st.bvalid;

        // read channel: one-cycle answer, unmapped answers slave error
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (s_axi_arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_reg(st, s_axi_araddr[7:0]);
            next_st.rresp = addr_ok(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid;

        // register writes; only the transfer path reaches them
        if (wr_go)
        begin
            wv = merge(read_reg(st, st.awaddr), st.wdata, st.wstrb);
            // any write but a command write with the arm bit breaks the arm-then-sleep pair
            next_st.armed = 1'b0;
            case (st.awaddr)
                OFF_CMD:
                begin
                    cmd = st.wstrb[0] ? st.wdata : 16'h0000;
                    next_st.armed = cmd[CMD_ARM];
                end
                OFF_KEYWAKE: next_st.keywake_en = wv[3:0];
                OFF_P1COND: next_st.p1_cond = wv[3:0];
                OFF_EXTWAKE: next_st.ext_cfg = wv[3:0];
                OFF_P0PU: next_st.p0_pu = wv[3:0];
                OFF_P1PU: next_st.p1_pu = wv[3:0];
                OFF_EXTCTRL: next_st.ext_ctrl = wv[3:0];
                OFF_CPUCTRL:
                begin
                    next_st.irq_pair = wv[7:0];
                    next_st.tmr_a = wv[CPU_TMRA_LSB +: 4];
                    next_st.irq_en = wv[CPU_IRQ_EN];
                    next_st.cnt_sel = wv[CPU_CSEL_LSB +: 2];
                end
                OFF_CPUSTATE:
                begin
                    next_st.stack = wv[2:0];
                    next_st.carry = wv[3];
                end
                default: ;
            endcase
        end

        // enable is one-shot; only aresetn takes it back, a cold start leaves it set
        if (cmd[CMD_VDROP_EN])
            next_st.vdrop_en = 1'b1;
        if (cmd[CMD_WD_RESTART])
            next_st.wd_restart = 1'b1;

        // flag clears first so that a same-cycle set wins
        if (cmd[CMD_T3F_CLEAR])
            next_st.t3f = 1'b0;
        if (cmd[CMD_T3F_SET] || (timer3_underflow && st.state != ST_RAM_SLEEP))
            next_st.t3f = 1'b1;
        if (cmd[CMD_EXT0_CLEAR])
            next_st.ext0 = 1'b0;
        if (st.state == ST_RUN && (st.ext_ctrl[EXTC_EDGE_RISE]
                ? (!st.int_prev && st.sync2[8]) : (st.int_prev && !st.sync2[8])))
            next_st.ext0 = 1'b1;

        // power-down sequencing
        case (st.state)
            ST_RUN:
            begin
                if (st.armed && cmd[CMD_RAM_SLEEP])
                    next_st.state = ST_RAM_SLEEP;
                else if (st.armed && cmd[CMD_CLK_SLEEP])
                    next_st.state = ST_CLK_SLEEP;
            end
            ST_CLK_SLEEP:
            begin
                // a flag left set at entry wakes at once
                if (wk.wake || st.t3f)
                    next_st.state = ST_WAKE;
                next_st.from_ram = 1'b0;
            end
            ST_RAM_SLEEP:
            begin
                // oscillator is stopped, so the timer flag cannot end this
                if (wk.wake)
                    next_st.state = ST_WAKE;
                // outputs already show the ram-hold state, so mark the mode here
                next_st.from_ram = 1'b1;
            end
            ST_WAKE:
            begin
                // restart from address zero with the warm flag up
                next_st.state = ST_RUN;
                next_st.cpu_restart = 1'b1;
                next_st.warm = 1'b1;
                next_st.stack = STACK_INIT;
                next_st.carry = 1'b0;
                // interrupt side reinitialised; level return never flags it
                next_st.irq_pair = 8'h00;
                next_st.tmr_a = 4'h0;
                next_st.ext0 = 1'b0;
                next_st.irq_en = 1'b0;
                // config, pull-up and wake registers are left untouched
                next_st.armed = 1'b0;
            end
            default: next_st.state = ST_RUN;
        endcase

        // watchdog or voltage-drop reset is a cold start
        if (cold_reset)
        begin
            next_st.state = ST_RUN;
            next_st.warm = 1'b0;
            next_st.cpu_restart = 1'b1;
            next_st.armed = 1'b0;
        end

        // pin and clock outputs follow the state being entered
        next_st.osc_run = next_st.state != ST_RAM_SLEEP;
        next_st.lcd_on = next_st.state != ST_RAM_SLEEP;
        next_st.cpu_halt = next_st.state inside {ST_CLK_SLEEP, ST_RAM_SLEEP};
        next_st.vdrop_rst_en = !next_st.cpu_halt || next_st.vdrop_en;
        if (next_st.cnt_sel == CNT_SEL_INPUT)
        begin
            next_st.cnt_oe = 1'b0;
            next_st.cnt_out = 1'b0;
        end
        else
        begin
            next_st.cnt_oe = 1'b1;
            next_st.cnt_out = (next_st.state == ST_RAM_SLEEP) ? 1'b0 : timer_counter_out;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= RST_VAL;
        else
            st <= next_st;
    end

    // every output straight from the state flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = {16'h0000, st.rdata};
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
    assign port0_pullup = st.p0_pu;
    assign port1_pullup = st.p1_pu;
    assign osc_run = st.osc_run;
    assign lcd_on = st.lcd_on;
    assign cpu_halt = st.cpu_halt;
    assign cpu_restart = st.cpu_restart;
    assign warm_flag = st.warm;
    assign combined_counter_pin_out = st.cnt_out;
    assign combined_counter_pin_oe = st.cnt_oe;
    assign vdrop_reset_enable = st.vdrop_rst_en;
    assign watchdog_restart = st.wd_restart;
    assign ext0_irq_flag = st.ext0;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    warm_set_a: assert property (st.state == ST_WAKE && !cold_reset |=> st.warm && cpu_restart)
        else $error("warm flag not set on wake");
    cold_clear_a: assert property (cold_reset |=> !st.warm && st.state == ST_RUN)
        else $error("cold start kept warm flag");
    stack_init_a: assert property (st.state == ST_WAKE && !cold_reset
        |=> st.stack == 3'h7 && !st.carry)
        else $error("stack level not seven after wake");
    irq_reinit_a: assert property (st.state == ST_WAKE
        |=> !st.irq_en && !st.ext0 && st.irq_pair == 8'h00 && st.tmr_a == 4'h0)
        else $error("interrupt state kept across wake");
    t3_keep_a: assert property (st.state == ST_CLK_SLEEP && st.t3f && !cold_reset
        |=> st.state == ST_WAKE ##1 st.t3f)
        else $error("timer 3 wake lost or flag cleared");
    ram_hold_a: assert property (st.state == ST_RAM_SLEEP && !wk.wake && !cold_reset
        |=> st.state == ST_RAM_SLEEP)
        else $error("ram-hold sleep left without external wake");
    arm_gate_a: assert property (st.state == ST_RUN && !st.armed
        |=> st.state != ST_CLK_SLEEP && st.state != ST_RAM_SLEEP)
        else $error("sleep entered without arming");
    counter_pin_a: assert property (st.state == ST_RAM_SLEEP
        |-> (st.cnt_sel == 2'h3) ? !combined_counter_pin_oe
            : (combined_counter_pin_oe && !combined_counter_pin_out))
        else $error("counter pin wrong in ram-hold sleep");
    lcd_osc_a: assert property (st.state == ST_RAM_SLEEP |-> !osc_run && !lcd_on && cpu_halt)
        else $error("oscillator or lcd running in ram-hold sleep");
    vdrop_a: assert property (cpu_halt && !st.vdrop_en |-> !vdrop_reset_enable)
        else $error("voltage-drop reset on in sleep without enable");

    clk_wake_c: cover property (st.state == ST_CLK_SLEEP ##1 st.state == ST_WAKE);
    ram_wake_c: cover property (st.state == ST_RAM_SLEEP ##1 st.state == ST_WAKE);
    level_wake_c: cover property (wk.wake_int_level && st.state == ST_RAM_SLEEP);
endmodule // power_down_wakeup_control

// ---- rtl/wake_detect.sv ----
// key-on and interrupt-pin wake condition detector
`timescale 1ns/1ps
module wake_detect
    import pdw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    wake_if.det wk
);
    typedef struct packed {
        logic [3:0] p0_prev;
        logic [3:0] p1_prev;
        logic int_prev;
        logic wake;
        logic int_level;
    } det_t;
    det_t st;
    det_t next_st;

    // pairs of pins share one enable bit
    function automatic logic pair_en(input logic [3:0] en, input int pin);
        return en[pin / 2];
    endfunction

    // per-pin conditions, or-ed into one registered wake request
    always_comb
    begin
        logic hit;
        logic pol;
        logic lvl;
        hit = 1'b0;
        pol = 1'b0;
        lvl = 1'b0;
        next_st = st;
        next_st.p0_prev = wk.p0;
        next_st.p1_prev = wk.p1;
        next_st.int_prev = wk.int_pin;
        for (int i = 0; i < 4; i++)
        begin
            // port zero wakes on high to low only
            if (pair_en(wk.keywake_en, i) && st.p0_prev[i] && !wk.p0[i])
                hit = 1'b1;
            pol = wk.p1_cond[2 * (i / 2)];
            lvl = wk.p1_cond[2 * (i / 2) + 1];
            if (pair_en(wk.keywake_en, i + 4))
            begin
                if (lvl ? (wk.p1[i] == pol)
                        : (pol ? (!st.p1_prev[i] && wk.p1[i])
                               : (st.p1_prev[i] && !wk.p1[i])))
                    hit = 1'b1;
            end
        end
        // interrupt pin: level from ext control, edge/level and enable here
        next_st.int_level = 1'b0;
        if (wk.ext_cfg[EXTW_ENABLE])
        begin
            if (!wk.ext_cfg[EXTW_EDGE])
            begin
                if (wk.int_pin == wk.ret_high)
                begin
                    hit = 1'b1;
                    next_st.int_level = 1'b1;
                end
            end
            else if (wk.ret_high ? (!st.int_prev && wk.int_pin)
                                 : (st.int_prev && !wk.int_pin))
                hit = 1'b1;
        end
        next_st.wake = hit;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign wk.wake = st.wake;
    assign wk.wake_int_level = st.int_level;
endmodule // wake_detect

// ---- rtl/wake_if.sv ----
// wake configuration and wake results between controller and detector
`timescale 1ns/1ps
interface wake_if;
    logic [3:0] keywake_en;
    logic [3:0] p1_cond;
    logic [3:0] ext_cfg;
    logic ret_high;
    logic [3:0] p0;
    logic [3:0] p1;
    logic int_pin;
    logic wake;
    logic wake_int_level;
    modport ctl (output keywake_en, p1_cond, ext_cfg, ret_high, p0, p1, int_pin,
        input wake, wake_int_level);
    modport det (input keywake_en, p1_cond, ext_cfg, ret_high, p0, p1, int_pin,
        output wake, wake_int_level);
endinterface // wake_if
